// ### design/hwps_pkg.sv
package hwps_pkg;
  // register map, byte-wide registers on the host side
  localparam logic [7:0] REG_CONFIG_COMMIT = 8'h1D;
  localparam logic [7:0] REG_APP_WATCHDOG_COUNTDOWN = 8'h20;
  localparam logic [7:0] REG_HOST_RUNNING_FLAG = 8'h21;

  localparam logic [7:0] COMMIT_MAGIC = 8'h46;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] FLAG_CLEAR = 8'h00;
  localparam logic [7:0] FLAG_SET = 8'h01;

  // watchdog configuration settings
  localparam logic [7:0] WD_CFG_OFF = 8'h00;
  localparam logic [7:0] WD_CFG_ALERT = 8'h01;
  localparam logic [7:0] WD_CFG_SHUTDOWN = 8'h02;

  // led patterns
  localparam logic [1:0] LED_DARK = 2'h0;
  localparam logic [1:0] LED_PULSE = 2'h1;
  localparam logic [1:0] LED_STEADY = 2'h2;
  localparam logic [1:0] LED_ERR_FLASH = 2'h3;

  // timebase
  localparam longint unsigned CORE_CLK_HZ = 10_000_000;
  localparam longint unsigned WD_TICK_PERIOD_S = 10;
  localparam int unsigned WD_TICK_CYCLES = int'(WD_TICK_PERIOD_S * CORE_CLK_HZ);
  localparam logic [31:0] PRESCALE_ZERO = 32'h0000_0000;
  localparam logic [31:0] PRESCALE_ONE = 32'h0000_0001;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_BOOT = 4'h2,
    ST_RUN = 4'h4,
    ST_SHDN = 4'h8
  } hwps_state_t;
endpackage

// ### design/hwps_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - enabled countdown decrements every ten seconds
// - each countdown write restarts from new value
// - reaching zero fires configured expiry action
// - host boot loads countdown with grace value
// - countdown byte at 0x20, read/write, volatile
// - running flag reads 0 unless host running
// - daemon sets flag; running, steady led, touch
// - touch or low battery clears running flag
// - shutdown pulses led then cuts host power
// - host writing 0 to flag starts shutdown
// - running flag byte at 0x21, read/write, volatile
// - magic 0x46 commit saves settings to flash
// - other commit values ignored; reads zero
// - commit register byte at 0x1D
// - configuration 0x00 disables countdown and action
// - configuration 0x01 expiry gives error flash
// - configuration 0x02 expiry starts host shutdown
module hwps_regs
  import hwps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] wd_cfg,
  input wire logic [7:0] wd_grace,
  input wire logic boot_request,
  input wire logic boot_timeout,
  input wire logic touch_press,
  input wire logic battery_below_shutdown_threshold,
  input wire logic battery_below_min,
  input wire logic host_halted,
  input wire logic shutdown_timeout,
  output logic host_power_en,
  output logic touch_accept,
  output logic [1:0] power_indicator_led,
  output logic flash_save
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    hit = (addr == offs);
  endfunction

  hwps_state_t state_q, state_d;
  logic [7:0] count_q, count_d;
  logic armed_q, armed_d;
  logic alert_q, alert_d;
  logic [31:0] pre_q, pre_d;
  logic [1:0] led_q, led_d;
  logic [7:0] rdata_q, rdata_d;
  logic save_q;

  // decode
  wire wr_count = reg_wr && hit(reg_addr, REG_APP_WATCHDOG_COUNTDOWN);
  wire wr_flag = reg_wr && hit(reg_addr, REG_HOST_RUNNING_FLAG);
  wire wr_commit = reg_wr && hit(reg_addr, REG_CONFIG_COMMIT);
  wire wd_on = (wd_cfg != WD_CFG_OFF);
  wire running = (state_q == ST_RUN);
  wire flag_val = running;
  wire boot_done = (state_q == ST_BOOT) && wr_flag && (reg_wdata != FLAG_CLEAR);
  wire host_stop = running && wr_flag && (reg_wdata == FLAG_CLEAR);

  // prescaler; restarted by a countdown write so the first step is a full period
  wire tick = wd_on && (pre_q == PRESCALE_ZERO);
  wire expire = tick && armed_q && (count_q <= COUNT_ONE) && !wr_count && !boot_done;
  wire exp_alert = expire && (wd_cfg == WD_CFG_ALERT);
  wire exp_shdn = expire && (wd_cfg == WD_CFG_SHUTDOWN);

  always_comb begin
    pre_d = pre_q - PRESCALE_ONE;
    if (wr_count || boot_done || !wd_on || pre_q == PRESCALE_ZERO) begin
      pre_d = TICK_CYCLES[31:0] - PRESCALE_ONE;
    end
  end

  // countdown; written values always stick, tick only while armed
  always_comb begin
    count_d = count_q;
    armed_d = armed_q;
    if (wr_count) begin
      count_d = reg_wdata;
      armed_d = 1'b1;
    end else if (boot_done) begin
      count_d = wd_grace;
      armed_d = 1'b1;
    end else if (expire) begin
      count_d = COUNT_RESET;
      armed_d = 1'b0;
    end else if (tick && armed_q) begin
      count_d = count_q - COUNT_ONE;
    end else if (state_q == ST_OFF) begin
      armed_d = 1'b0;
    end
  end

  // alert set wins over the ST_OFF clear; a fresh countdown write blocks expiry, so its clear wins
  always_comb begin
    alert_d = alert_q;
    if (wr_count || state_q == ST_OFF) begin
      alert_d = 1'b0;
    end
    if (exp_alert) begin
      alert_d = 1'b1;
    end
  end

  // host power state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (boot_request) begin
          state_d = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (battery_below_min || boot_timeout) begin
          state_d = ST_OFF;
        end else if (boot_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (battery_below_min) begin
          state_d = ST_OFF;
        end else if (host_stop || touch_press || battery_below_shutdown_threshold) begin
          state_d = ST_SHDN;
        end else if (exp_shdn) begin
          state_d = ST_SHDN;
        end
      end
      ST_SHDN: begin
        // forced off covers a host that never halts
        if (host_halted || shutdown_timeout || battery_below_min) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_comb begin
    unique case (state_d)
      ST_OFF: led_d = LED_DARK;
      ST_BOOT: led_d = LED_PULSE;
      ST_RUN: led_d = alert_d ? LED_ERR_FLASH : LED_STEADY;
      ST_SHDN: led_d = LED_PULSE;
      default: led_d = LED_DARK;
    endcase
  end

  // read mux; the commit register reads zero like unmapped space
  always_comb begin
    rdata_d = READ_ZERO;
    if (hit(reg_addr, REG_APP_WATCHDOG_COUNTDOWN)) begin
      rdata_d = count_q;
    end else if (hit(reg_addr, REG_HOST_RUNNING_FLAG)) begin
      rdata_d = flag_val ? FLAG_SET : FLAG_CLEAR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_OFF;
      count_q <= COUNT_RESET;
      armed_q <= 1'b0;
      alert_q <= 1'b0;
      pre_q <= PRESCALE_ZERO;
      led_q <= LED_DARK;
      rdata_q <= READ_ZERO;
      save_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      armed_q <= armed_d;
      alert_q <= alert_d;
      pre_q <= pre_d;
      led_q <= led_d;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
      save_q <= wr_commit && (reg_wdata == COMMIT_MAGIC);
    end
  end

  assign reg_rdata = rdata_q;
  assign host_power_en = (state_q != ST_OFF);
  assign touch_accept = running;
  assign power_indicator_led = led_q;
  assign flash_save = save_q;

  property p_write_loads;
    @(posedge core_clk) disable iff (reset)
      wr_count |=> (count_q == $past(reg_wdata));
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("countdown write lost");

  property p_decrement;
    @(posedge core_clk) disable iff (reset)
      (tick && armed_q && count_q > COUNT_ONE && !wr_count && !boot_done)
        |=> (count_q == $past(count_q) - COUNT_ONE);
  endproperty
  a_decrement: assert property (p_decrement) else $error("countdown did not step");

  property p_disabled_hold;
    @(posedge core_clk) disable iff (reset)
      (!wd_on && !wr_count && !boot_done) |=> (count_q == $past(count_q)) && !$past(expire);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("disabled countdown moved");

  property p_grace;
    @(posedge core_clk) disable iff (reset)
      (boot_done && !wr_count && !battery_below_min && !boot_timeout)
        |=> (count_q == $past(wd_grace)) && (state_q == ST_RUN);
  endproperty
  a_grace: assert property (p_grace) else $error("grace not loaded on boot");

  property p_alert;
    @(posedge core_clk) disable iff (reset)
      (exp_alert && running && !host_stop && !touch_press && !battery_below_shutdown_threshold
       && !battery_below_min) |=> (power_indicator_led == LED_ERR_FLASH);
  endproperty
  a_alert: assert property (p_alert) else $error("no error flash on expiry");

  property p_expiry_shdn;
    @(posedge core_clk) disable iff (reset)
      (exp_shdn && running && !battery_below_min) |=> (state_q == ST_SHDN) && !flag_val;
  endproperty
  a_expiry_shdn: assert property (p_expiry_shdn) else $error("no shutdown on expiry");

  property p_flag_reads_zero;
    @(posedge core_clk) disable iff (reset)
      (reg_rd && hit(reg_addr, REG_HOST_RUNNING_FLAG) && !running) |=> (reg_rdata == FLAG_CLEAR);
  endproperty
  a_flag_reads_zero: assert property (p_flag_reads_zero) else $error("flag read high");

  property p_run_steady;
    @(posedge core_clk) disable iff (reset)
      (boot_done && !battery_below_min && !boot_timeout && !alert_d)
        |=> running && touch_accept && (power_indicator_led == LED_STEADY);
  endproperty
  a_run_steady: assert property (p_run_steady) else $error("boot did not reach run");

  property p_clear_sources;
    @(posedge core_clk) disable iff (reset)
      (running && !battery_below_min && (touch_press || battery_below_shutdown_threshold || host_stop))
        |=> (state_q == ST_SHDN) ##0 (power_indicator_led == LED_PULSE) ##0 host_power_en;
  endproperty
  a_clear_sources: assert property (p_clear_sources) else $error("flag not cleared");

  property p_host_stop;
    @(posedge core_clk) disable iff (reset)
      host_stop |=> !running;
  endproperty
  a_host_stop: assert property (p_host_stop) else $error("write 0 ignored");

  property p_power_off;
    @(posedge core_clk) disable iff (reset)
      ((state_q == ST_SHDN) && host_halted)
        |=> !host_power_en ##1 (!host_power_en || $past(boot_request));
  endproperty
  a_power_off: assert property (p_power_off) else $error("host power kept on");

  property p_commit;
    @(posedge core_clk) disable iff (reset)
      flash_save |-> $past(wr_commit) && ($past(reg_wdata) == COMMIT_MAGIC);
  endproperty
  a_commit: assert property (p_commit) else $error("stray flash save");

  property p_commit_fires;
    @(posedge core_clk) disable iff (reset)
      (wr_commit && reg_wdata == COMMIT_MAGIC) |=> flash_save ##1 !flash_save || $past(wr_commit);
  endproperty
  a_commit_fires: assert property (p_commit_fires) else $error("magic write missed");

  property p_commit_reads_zero;
    @(posedge core_clk) disable iff (reset)
      (reg_rd && hit(reg_addr, REG_CONFIG_COMMIT)) |=> (reg_rdata == READ_ZERO);
  endproperty
  a_commit_reads_zero: assert property (p_commit_reads_zero) else $error("commit read nonzero");

  property p_tick_gap;
    @(posedge core_clk) disable iff (reset)
      (tick && !wr_count && !boot_done && wd_on) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

  property p_expire_zero;
    @(posedge core_clk) disable iff (reset)
      expire |=> (count_q == COUNT_RESET) && !armed_q;
  endproperty
  a_expire_zero: assert property (p_expire_zero) else $error("expiry not at zero");

  c_boot_run: cover property (@(posedge core_clk) disable iff (reset) boot_done ##1 running);
  c_alert: cover property (@(posedge core_clk) disable iff (reset) exp_alert);
  c_wd_shdn: cover property (@(posedge core_clk) disable iff (reset) exp_shdn && running);
  c_commit: cover property (@(posedge core_clk) disable iff (reset) flash_save);

endmodule

// ### verification/hwps_host_model.sv
`timescale 1ns/10ps
module hwps_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic host_halted
);
  import hwps_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    host_halted = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // released data is not left looking valid
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic daemon_start();
    wr(REG_HOST_RUNNING_FLAG, FLAG_SET);
  endtask
  task automatic app_service(input logic [7:0] n);
    wr(REG_APP_WATCHDOG_COUNTDOWN, n);
  endtask
  // flag seen low: host halts its kernel
  task automatic daemon_poll(output logic [7:0] f);
    rd(REG_HOST_RUNNING_FLAG, f);
    if (f === FLAG_CLEAR) begin
      @(negedge core_clk);
      host_halted = 1'b1;
      @(negedge core_clk);
      host_halted = 1'b0;
    end
  endtask
endmodule

// ### verification/hwps_regs_tb.sv
`timescale 1ns/10ps
module hwps_regs_tb;
  import hwps_pkg::*;
  // short tick keeps the run small
  localparam int unsigned TK = 8;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [7:0] wd_cfg = WD_CFG_OFF;
  logic [7:0] wd_grace = 8'h05;
  logic reg_wr, reg_rd, host_halted, host_power_en, touch_accept, flash_save;
  logic boot_request = 1'b0;
  logic boot_timeout = 1'b0;
  logic touch_press = 1'b0;
  logic bat_shdn = 1'b0;
  logic bat_min = 1'b0;
  logic shutdown_timeout = 1'b0;
  logic [1:0] led;
  int num_errors = 0;
  int checks = 0;
  int saves = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (flash_save === 1'b1) saves++;
  hwps_regs #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wd_cfg(wd_cfg), .wd_grace(wd_grace),
    .boot_request(boot_request), .boot_timeout(boot_timeout), .touch_press(touch_press),
    .battery_below_shutdown_threshold(bat_shdn), .battery_below_min(bat_min),
    .host_halted(host_halted), .shutdown_timeout(shutdown_timeout),
    .host_power_en(host_power_en), .touch_accept(touch_accept),
    .power_indicator_led(led), .flash_save(flash_save));
  hwps_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_halted(host_halted));
  task automatic fail(input logic [7:0] g, input logic [7:0] e);
    num_errors++;
    $display("[FAIL] %0t got %h expected %h", $time, g, e);
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) fail(g, e);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) fail({7'h00, g}, {7'h00, e});
  endtask
  task automatic chk_led(input logic [1:0] e);
    checks++;
    if (led !== e) fail({6'h00, led}, {6'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_boot();
    @(negedge core_clk);
    boot_request = 1'b1;
    @(negedge core_clk);
    boot_request = 1'b0;
  endtask
  task automatic t_reset();
    host.rd(REG_APP_WATCHDOG_COUNTDOWN, rv);
    chk_byte(rv, COUNT_RESET);
    host.rd(REG_HOST_RUNNING_FLAG, rv);
    chk_byte(rv, FLAG_CLEAR);
    host.rd(8'h55, rv);
    chk_byte(rv, READ_ZERO);
    chk_bit(host_power_en, 1'b0);
    chk_led(LED_DARK);
  endtask
  task automatic t_boot();
    do_boot();
    chk_bit(host_power_en, 1'b1);
    chk_led(LED_PULSE);
    host.rd(REG_HOST_RUNNING_FLAG, rv);
    chk_byte(rv, FLAG_CLEAR);
    host.daemon_start();
    chk_bit(touch_accept, 1'b1);
    chk_led(LED_STEADY);
    host.rd(REG_HOST_RUNNING_FLAG, rv);
    chk_byte(rv, FLAG_SET);
    host.rd(REG_APP_WATCHDOG_COUNTDOWN, rv);
    chk_byte(rv, wd_grace);
  endtask
  task automatic t_commit();
    host.wr(REG_CONFIG_COMMIT, 8'h45);
    cyc(2);
    chk_byte(8'(saves), 8'h00);
    host.wr(REG_CONFIG_COMMIT, COMMIT_MAGIC);
    cyc(2);
    chk_byte(8'(saves), 8'h01);
    host.rd(REG_CONFIG_COMMIT, rv);
    chk_byte(rv, READ_ZERO);
  endtask
  task automatic t_watchdog();
    host.app_service(8'h02);
    cyc(5 * TK);
    host.rd(REG_APP_WATCHDOG_COUNTDOWN, rv);
    chk_byte(rv, 8'h02);
    wd_cfg = WD_CFG_ALERT;
    host.app_service(8'h03);
    cyc(2 * TK + 4);
    host.app_service(8'h03);
    cyc(TK + 3);
    host.rd(REG_APP_WATCHDOG_COUNTDOWN, rv);
    chk_byte(rv, 8'h02);
    cyc(4);
    chk_led(LED_STEADY);
    for (int i = 0; i < 2 * TK && led !== LED_ERR_FLASH; i++) @(negedge core_clk);
    chk_led(LED_ERR_FLASH);
    host.rd(REG_APP_WATCHDOG_COUNTDOWN, rv);
    chk_byte(rv, COUNT_RESET);
    host.app_service(8'h09);
    chk_led(LED_STEADY);
    wd_cfg = WD_CFG_SHUTDOWN;
    host.app_service(COUNT_ONE);
    for (int i = 0; i < 2 * TK && touch_accept !== 1'b0; i++) @(negedge core_clk);
    chk_bit(touch_accept, 1'b0);
    chk_led(LED_PULSE);
    wd_cfg = WD_CFG_OFF;
    host.daemon_poll(rv);
    chk_byte(rv, FLAG_CLEAR);
    cyc(1);
    chk_bit(host_power_en, 1'b0);
  endtask
  task automatic t_sources();
    for (int k = 0; k < 3; k++) begin
      do_boot();
      host.daemon_start();
      @(negedge core_clk);
      if (k == 0) host.wr(REG_HOST_RUNNING_FLAG, FLAG_CLEAR);
      if (k == 1) touch_press = 1'b1;
      if (k == 2) bat_shdn = 1'b1;
      cyc(2);
      touch_press = 1'b0;
      chk_bit(touch_accept, 1'b0);
      chk_led(LED_PULSE);
      chk_bit(host_power_en, 1'b1);
      bat_shdn = 1'b0;
      shutdown_timeout = 1'b1;
      cyc(1);
      shutdown_timeout = 1'b0;
      cyc(1);
      chk_bit(host_power_en, 1'b0);
    end
    do_boot();
    bat_min = 1'b1;
    cyc(2);
    chk_bit(host_power_en, 1'b0);
    bat_min = 1'b0;
    do_boot();
    boot_timeout = 1'b1;
    cyc(1);
    boot_timeout = 1'b0;
    chk_bit(host_power_en, 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    num_errors++;
    final_report();
  end
  initial begin
    cyc(4);
    reset = 1'b0;
    t_reset();
    t_boot();
    t_commit();
    t_watchdog();
    t_sources();
    final_report();
  end
endmodule
